// ==== logic/dsp_pkg.sv ====
package dsp_pkg;
  // word layout
  localparam int WORD_BITS = 24;
  localparam int ADDR_MSB = 23;
  localparam int ADDR_LSB = 16;
  localparam int DATA_BITS = 16;
  // address byte decode
  localparam logic [7:0] ADDR_NOP = 8'h00;
  localparam logic [7:0] ADDR_DAC_CODE = 8'h01;
  localparam logic [7:0] ADDR_READBACK = 8'h02;
  localparam logic [7:0] ADDR_CONFIG = 8'h55;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h56;
  // read selector
  localparam logic [1:0] RSEL_STATUS = 2'h0;
  localparam logic [1:0] RSEL_DAC_CODE = 2'h1;
  localparam logic [1:0] RSEL_CONFIG = 2'h2;
  // configuration fields
  localparam int CFG_OUT_ON_BIT = 12;
  localparam int CFG_CHAIN_BIT = 3;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // host side timing: 30 MHz ceiling on the shift clock
  localparam int CLK_SYS_MHZ = 200;
  localparam int SCLK_MAX_MHZ = 30;
  localparam int SCLK_HALF_CYC = (CLK_SYS_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
  // wishbone register offsets of the host controller
  localparam logic [3:0] HR_TX_WORD = 4'h0;
  localparam logic [3:0] HR_CTRL = 4'h4;
  localparam logic [3:0] HR_STATUS = 4'h8;
  localparam logic [3:0] HR_RX_WORD = 4'hC;
  localparam int HR_CTRL_START = 0;
  localparam int HR_CTRL_LEN = 8;
endpackage

// ==== logic/dsp_link_if.sv ====
`timescale 1ns/1ps
interface dsp_link_if;
  logic sclk;
  logic serialDataIn;
  logic latch;
  logic serialDataOut;
  logic serialDataOutEn_n;
  modport device (input sclk, input serialDataIn, input latch,
    output serialDataOut, output serialDataOutEn_n);
  modport host (output sclk, output serialDataIn, output latch,
    input serialDataOut, input serialDataOutEn_n);
endinterface

// ==== logic/dsp_device.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - shift clock up to 30 MHz
// - 24-bit words, MSB first, shift register
// - sample data on each rising shift clock
// - bits 23:16 address, 15:0 data
// - latch rise commits last 24 bits
// - shifting continues whatever the latch level
// - decode nop, code, readback, config, reset
// - host gives exactly 24 edges per word
// - wrong edge count word may be dropped
// - free clock needs latch right after bits
// - gated burst exact, latch after last
// - MSB edge starts a write cycle
// - chain mode only while chain bit set
// - chain mode: old bits leave via output
// - serial output changes on falling edge, except the readback MSB, which is set on the latch strobe
// - chain of n needs 24n clocks
// - top four code bits thermometer, rest ladder
// - host clears output enable before range change
// - readback selector, next word a nop
// - readback output enabled, released by latch
// - code from 15:4 or 15:0 by variant
// - power-on clears every register except sdoEn_n, which is set to 1
module dsp_device import dsp_pkg::*; #(
  parameter int CODE_BITS = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // link
  dsp_link_if.device link,
  // analog side controls
  output logic [15:0] dacCode,
  output logic [15:0] configWord,
  output logic analogOutputOn,
  output logic [14:0] thermometerSwitches,
  output logic [CODE_BITS-5:0] ladderSwitches,
  output logic wordRejected
);
  typedef struct packed {
    logic [1:0] sclkSync;
    logic [1:0] latchSync;
    logic [1:0] sdinSync;
    logic sclkPrev;
    logic latchPrev;
    logic [23:0] shiftWord;
    logic [5:0] edgeCount;
    logic [15:0] dacCode;
    logic [15:0] configWord;
    logic [15:0] readData;
    logic readArmed;
    logic readPending;
    logic readActive;
    logic [4:0] readCount;
    logic serial_data_out;
    logic sdoEn_n;
    logic [14:0] therm;
    logic [CODE_BITS-5:0] ladder;
    logic rejected;
  } dsp_dev_s;

  dsp_dev_s r, next_r;

  // thermometer decode of a 4-bit field
  function automatic logic [14:0] thermo(input logic [3:0] v);
    logic [14:0] t;
    t = '0;
    for (int i = 0; i < 15; i++) begin
      t[i] = (32'(v) > i);
    end
    return t;
  endfunction

  logic sclkRise, sclkFall, latchRise, chainOn;
  logic [23:0] shifted;
  logic [15:0] codeNext;
  logic [15:0] rbData;

  // edges come from the second synchroniser stage only
  assign sclkRise = r.sclkSync[1] & ~r.sclkPrev;
  assign sclkFall = ~r.sclkSync[1] & r.sclkPrev;
  assign latchRise = r.latchSync[1] & ~r.latchPrev;
  assign chainOn = r.configWord[CFG_CHAIN_BIT];
  assign shifted = {r.shiftWord[22:0], r.sdinSync[1]};

  always_comb begin
    next_r = r;
    codeNext = r.dacCode;
    rbData = 16'h0000;
    next_r.sclkSync = {r.sclkSync[0], link.sclk};
    next_r.latchSync = {r.latchSync[0], link.latch};
    next_r.sdinSync = {r.sdinSync[0], link.serialDataIn};
    next_r.sclkPrev = r.sclkSync[1];
    next_r.latchPrev = r.latchSync[1];
    next_r.rejected = 1'b0;
    // shifting runs whatever latch does; sclk at most 30 MHz keeps 3+ samples per half
    if (sclkRise) begin
      next_r.shiftWord = shifted;
      // first edge after a commit starts the write cycle
      if (r.edgeCount != 6'h3F) begin
        next_r.edgeCount = r.edgeCount + 6'h01;
      end
      if (r.readActive && r.readCount != 5'h00) begin
        next_r.readCount = r.readCount - 5'h01;
      end
    end
    // serial output moves on the falling edge
    if (sclkFall) begin
      if (r.readActive) begin
        // count already stepped on the rise, so it points one past the bit
        if (r.readCount != 5'h00) begin
          next_r.serial_data_out = r.readData[4'(r.readCount - 5'h01)];
        end else begin
          next_r.serial_data_out = 1'b0;
        end
      end else if (chainOn) begin
        next_r.serial_data_out = r.shiftWord[23];
      end
    end
    if (latchRise) begin
      next_r.edgeCount = 6'h00;
      // readback window closes on the latch after the data left
      next_r.readActive = 1'b0;
      next_r.readPending = 1'b0;
      // chain mode accepts any edge count; standalone needs exactly 24
      if (!chainOn && r.edgeCount != 6'(WORD_BITS)) begin
        next_r.rejected = 1'b1;
      end else begin
        unique case (r.shiftWord[ADDR_MSB:ADDR_LSB])
          ADDR_NOP: ;
          ADDR_DAC_CODE: begin
            if (CODE_BITS == 12) begin
              codeNext = {r.shiftWord[15:4], 4'h0};
            end else begin
              codeNext = r.shiftWord[15:0];
            end
            next_r.dacCode = codeNext;
          end
          ADDR_READBACK: begin
            next_r.readPending = 1'b1;
            case (r.shiftWord[1:0])
              RSEL_STATUS: rbData = {15'h0000, r.readPending};
              RSEL_DAC_CODE: rbData = r.dacCode;
              RSEL_CONFIG: rbData = r.configWord;
              default: rbData = 16'h0000;
            endcase
            // the strobe of the request opens the output so the next nop carries data
            next_r.readData = rbData;
            next_r.readActive = 1'b1;
            next_r.readCount = 5'h10;
            next_r.serial_data_out = rbData[15];
          end
          ADDR_CONFIG: next_r.configWord = r.shiftWord[15:0];
          ADDR_SOFT_RESET: begin
            next_r.dacCode = REG_RESET;
            next_r.configWord = REG_RESET;
            next_r.readPending = 1'b0;
            next_r.readActive = 1'b0;
            codeNext = REG_RESET;
          end
          default: ;
        endcase
      end
    end
    // split the code into thermometer and ladder switch controls
    next_r.therm = thermo(codeNext[15:12]);
    next_r.ladder = codeNext[15-4 -: CODE_BITS-4];
    // driven only while chaining or a readback is open
    next_r.sdoEn_n = ~(next_r.readActive | next_r.configWord[CFG_CHAIN_BIT]);
  end

  // single register stage for all state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r <= '0;
      r.sdoEn_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign link.serialDataOut = r.serial_data_out;
  assign link.serialDataOutEn_n = r.sdoEn_n;
  assign dacCode = r.dacCode;
  assign configWord = r.configWord;
  assign analogOutputOn = r.configWord[CFG_OUT_ON_BIT];
  assign thermometerSwitches = r.therm;
  assign ladderSwitches = r.ladder;
  assign wordRejected = r.rejected;
endmodule

// ==== logic/dsp_host.sv ====
`timescale 1ns/1ps
// host end: wishbone slave that shifts one burst and latches it
module dsp_host import dsp_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // wishbone slave
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  // link
  dsp_link_if.host link
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW = 2'b01,
    ST_HIGH = 2'b10,
    ST_LATCH = 2'b11
  } dsp_hst_e;

  typedef struct packed {
    dsp_hst_e state;
    logic [23:0] txWord;
    logic [23:0] rxWord;
    logic [7:0] bitsLeft;
    logic [7:0] halfCount;
    logic [1:0] sdoSync;
    logic sclk;
    logic serial_data_in;
    logic latch;
    logic ack;
    logic [31:0] rdata;
  } dsp_hst_s;

  dsp_hst_s r, next_r;
  logic wbReq;

  assign wbReq = wb_cyc_i & wb_stb_i & ~r.ack;

  always_comb begin
    next_r = r;
    next_r.sdoSync = {r.sdoSync[0], link.serialDataOut};
    next_r.ack = wbReq;
    // register access, one wait cycle
    if (wbReq) begin
      next_r.rdata = 32'h0000_0000;
      case (wb_adr_i)
        HR_TX_WORD: begin
          if (wb_we_i && r.state == ST_IDLE) next_r.txWord = wb_dat_i[23:0];
          next_r.rdata = {8'h00, r.txWord};
        end
        HR_CTRL: begin
          // bit count lets the host run a daisy chain of 24n clocks
          if (wb_we_i && wb_dat_i[HR_CTRL_START] && r.state == ST_IDLE) begin
            next_r.bitsLeft = wb_dat_i[HR_CTRL_LEN +: 8];
            next_r.state = ST_LOW;
            next_r.halfCount = 8'h00;
          end
        end
        HR_STATUS: next_r.rdata = {31'h0, r.state != ST_IDLE};
        HR_RX_WORD: next_r.rdata = {8'h00, r.rxWord};
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end
    // gated burst: exact edge count then latch, halves no shorter than 30 MHz allows
    case (r.state)
      ST_IDLE: next_r.latch = 1'b0;
      ST_LOW: begin
        next_r.latch = 1'b0;
        if (r.halfCount == 8'(SCLK_HALF_CYC - 1)) begin
          next_r.halfCount = 8'h00;
          next_r.sclk = 1'b1;
          next_r.state = ST_HIGH;
        end else begin
          next_r.halfCount = r.halfCount + 8'h01;
          if (r.halfCount == 8'h00) begin
            next_r.serial_data_in = r.txWord[23];
          end
        end
      end
      ST_HIGH: begin
        if (r.halfCount == 8'(SCLK_HALF_CYC - 1)) begin
          next_r.halfCount = 8'h00;
          next_r.sclk = 1'b0;
          // sample late in the high phase: the synchronised return path needs the time
          next_r.rxWord = {r.rxWord[22:0], r.sdoSync[1]};
          next_r.txWord = {r.txWord[22:0], 1'b0};
          next_r.bitsLeft = r.bitsLeft - 8'h01;
          next_r.state = (r.bitsLeft == 8'h01) ? ST_LATCH : ST_LOW;
        end else begin
          next_r.halfCount = r.halfCount + 8'h01;
        end
      end
      ST_LATCH: begin
        // latch follows the last clock directly
        next_r.latch = 1'b1;
        if (r.halfCount == 8'(SCLK_HALF_CYC - 1)) begin
          next_r.state = ST_IDLE;
          next_r.halfCount = 8'h00;
        end else begin
          next_r.halfCount = r.halfCount + 8'h01;
        end
      end
      default: next_r.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign link.sclk = r.sclk;
  assign link.serialDataIn = r.serial_data_in;
  assign link.latch = r.latch;
  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.rdata;
endmodule

// ==== verification/dsp_link_sva.sv ====
`timescale 1ns/1ps
module dsp_link_sva import dsp_pkg::*; #(
  parameter int CODE_BITS = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // link wires
  input wire logic sclk,
  input wire logic serialDataIn,
  input wire logic latch,
  input wire logic serialDataOut,
  input wire logic serialDataOutEn_n,
  // device outputs
  input wire logic [15:0] dacCode,
  input wire logic [15:0] configWord,
  input wire logic analogOutputOn,
  input wire logic [14:0] thermometerSwitches,
  input wire logic [CODE_BITS-5:0] ladderSwitches,
  input wire logic wordRejected
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic [7:0] latchHist;
  // commits land a few cycles after the strobe, so keep a short history
  always_ff @(posedge clk_sys) begin
    latchHist <= srst ? 8'h00 : {latchHist[6:0], latch};
  end
  sequence sclkHighRun;
    sclk [*4];
  endsequence
  sequence latchRecent;
    |latchHist;
  endsequence
  AST_SCLK_RATE: assert property ($rose(sclk) |-> sclkHighRun)
    else $error("shift clock high phase too short");
  AST_CODE_ON_LATCH: assert property ($changed(dacCode) |-> latchRecent)
    else $error("code changed without a latch strobe");
  AST_CFG_ON_LATCH: assert property ($changed(configWord) |-> latchRecent)
    else $error("config changed without a latch strobe");
  AST_REJECT_ON_LATCH: assert property (wordRejected |-> latchRecent)
    else $error("reject pulse without a latch strobe");
  AST_THERMO: assert property ($stable(dacCode) |->
    thermometerSwitches == 15'(16'hFFFF >> (16 - dacCode[15:12])))
    else $error("thermometer controls do not match code");
  AST_LADDER: assert property ($stable(dacCode) |->
    ladderSwitches == dacCode[CODE_BITS-5:0])
    else $error("ladder controls do not match code");
  AST_OUT_ON: assert property ($stable(configWord) |->
    analogOutputOn == configWord[CFG_OUT_ON_BIT])
    else $error("output enable does not follow config");
  AST_SDO_FALL: assert property ($changed(serialDataOut) && !serialDataOutEn_n
    && $past(!serialDataOutEn_n) |-> !$past(sclk) || !$past(sclk, 2))
    else $error("serial output moved in the high phase");
  AST_SDO_EN: assert property ($fell(serialDataOutEn_n) && !configWord[CFG_CHAIN_BIT]
    |-> latchRecent)
    else $error("serial output enabled without a latch strobe");
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
module tb import dsp_pkg::*; ;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [3:0] wbAdr = 4'h0;
  logic [31:0] wbDatI = 32'h0;
  logic [31:0] wbDatO;
  logic wbWe = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbAck;
  logic [15:0] dacCode;
  logic [15:0] configWord;
  logic outOn;
  logic [14:0] thermo;
  logic [11:0] ladder;
  logic rejected;
  logic rejSeen = 1'b0;
  logic [31:0] rd;
  logic [15:0] code;
  logic [31:0] expQ[$];
  int err_count = 0;
  int compares = 0;
  dsp_link_if link();
  dsp_host u_dsp_host(.clk_sys(clk_sys), .srst(srst), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_we_i(wbWe), .wb_sel_i(4'hF), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_ack_o(wbAck), .link(link.host));
  dsp_device u_dsp_device(.clk_sys(clk_sys), .srst(srst), .link(link.device),
    .dacCode(dacCode), .configWord(configWord), .analogOutputOn(outOn),
    .thermometerSwitches(thermo), .ladderSwitches(ladder), .wordRejected(rejected));
  dsp_link_sva u_dsp_link_sva(.clk_sys(clk_sys), .srst(srst), .sclk(link.sclk),
    .serialDataIn(link.serialDataIn), .latch(link.latch), .serialDataOut(link.serialDataOut),
    .serialDataOutEn_n(link.serialDataOutEn_n), .dacCode(dacCode), .configWord(configWord),
    .analogOutputOn(outOn), .thermometerSwitches(thermo), .ladderSwitches(ladder),
    .wordRejected(rejected));
  always #2.5 clk_sys = ~clk_sys;
  // the reject pulse lasts one cycle, so latch it for later checking
  always @(posedge clk_sys) begin
    if (rejected === 1'b1) rejSeen <= 1'b1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // read answers are paired with notes in issue order
  always @(posedge clk_sys) begin
    if (wbAck === 1'b1 && wbWe === 1'b0 && expQ.size() > 0) check(wbDatO, expQ.pop_front());
  end
  task automatic wb(input logic [3:0] a, input logic [31:0] d, input logic we,
    output logic [31:0] q);
    wbAdr <= a;
    wbDatI <= d;
    wbWe <= we;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (wbAck !== 1'b1);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk_sys);
  endtask
  // one burst of len clocks, then wait out the commit delay
  task automatic send(input logic [23:0] w, input logic [7:0] len);
    logic [31:0] st;
    int n;
    n = 0;
    wb(HR_TX_WORD, {8'h00, w}, 1'b1, st);
    wb(HR_CTRL, (32'(len) << HR_CTRL_LEN) | 32'h1, 1'b1, st);
    do begin
      wb(HR_STATUS, 32'h0, 1'b0, st);
      n++;
    end while (st[0] !== 1'b0 && n < 400);
    if (n >= 400) err_count++;
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic print_verdict();
    if (err_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #300000;
    err_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h3ECFF905));
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    check(dacCode, 32'h0);
    check(configWord, 32'h0);
    code = 16'($urandom());
    send({ADDR_DAC_CODE, code}, 8'd24);
    check(dacCode, code);
    check(thermo, 32'(15'h7FFF >> (15 - code[15:12])));
    check(ladder, code[11:0]);
    // too few and too many edges must both be dropped
    for (int i = 0; i < 2; i++) begin
      rejSeen <= 1'b0;
      send({ADDR_DAC_CODE, ~code}, 8'(23 + 2 * i));
      check(dacCode, code);
      check(rejSeen, 1'b1);
    end
    send(24'h000000, 8'd24);
    check(dacCode, code);
    send({ADDR_CONFIG, 16'h1000}, 8'd24); // output enable set only, range untouched
    check(outOn, 1'b1);
    for (int s = 1; s < 3; s++) begin
      send({ADDR_READBACK, 14'h0, 2'(s)}, 8'd24);
      send(24'h000000, 8'd24);
      expQ.push_back({8'h00, (s == 1) ? code : 16'h1000, 8'h00});
      wb(HR_RX_WORD, 32'h0, 1'b0, rd);
    end
    check(link.serialDataOutEn_n, 1'b1);
    expQ.push_back(32'h0);
    wb(4'h2, 32'h0, 1'b0, rd);
    send({ADDR_SOFT_RESET, 16'h0000}, 8'd24);
    check({dacCode, configWord}, 32'h0);
    check(outOn, 1'b0);
    print_verdict();
  end
endmodule
